// ===== aep_top.sv
// Absolute encoder position, battery alarms, setup and Wishbone readout
//
// The placing of the registers and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
`include "aep_defs.svh"

// Summary of operation
// - Forward past top wraps to most negative
// - Reverse past bottom wraps to most positive
// - Absolute position readable by outside party
// - Usage field 0 absolute, 1 incremental
// - Usage change applies only after power cycle
// - Battery below first threshold raises low alarm, in absolute usage only
// - Below lower threshold, in absolute usage only: lost alarm, multiturn invalid
// - Battery-low alarm cleared only by setup or clear utility
// - Setup accepted only with servo off
// - Alarm reset input never clears encoder alarms
// - Internal encoder faults clear only at power-off
module aep_top
    import aep_pkg::*;
#(
    parameter int MT_WIDTH = 16,
    parameter int ST_WIDTH = 17
) (
    // Clock, reset, enable
    input  wire logic                clk_sys_in,
    input  wire logic                reset_n_in,
    input  wire logic                ce_in,
    // Wishbone slave
    input  wire aep_wb_req_t         wb_req_in,
    output logic [31:0]              wb_dat_out,
    output logic                     wb_ack_out,
    // Encoder data, same clock domain
    input  wire logic                enc_fwd_turn_in,
    input  wire logic                enc_rev_turn_in,
    input  wire logic [ST_WIDTH-1:0] enc_sturn_in,
    input  wire logic                enc_abs_fault_in,
    input  wire logic                enc_int_fault_in,
    // Stored usage setting presented at power-up
    input  wire logic                encoder_usage_nv_in,
    // Pins from outside the clock domain
    input  wire logic                batt_below_low_in,
    input  wire logic                batt_below_lost_in,
    input  wire logic                servo_on_in,
    input  wire logic                alarm_reset_input_n_in,
    // Panel utilities, one-cycle pulses
    input  wire logic                encoder_setup_utility_in,
    input  wire logic                encoder_alarm_clear_utility_in,
    // Status outputs
    output logic                     encoder_usage_pend_out,
    output logic                     incremental_mode_out,
    output logic [MT_WIDTH-1:0]      multiturn_out,
    output logic                     multiturn_valid_out,
    output aep_alarm_t               alarm_out,
    output logic                     abs_alarm_out,
    output logic                     util_done_out,
    output logic                     setup_refused_out
);

    // Synchronised pins
    logic [3:0] pins_s;
    wire  batt_low_s   = pins_s[0];
    wire  batt_lost_s  = pins_s[1];
    wire  servo_on_s   = pins_s[2];
    wire  alarm_reset_input_n_s  = ~pins_s[3]; // Carried inverted so the reset state reads idle

    aep_sync #(
        .WIDTH (4)
    ) u_sync (
        .clk_sys_in (clk_sys_in),
        .reset_n_in (reset_n_in),
        .ce_in      (ce_in),
        .async_in   ({~alarm_reset_input_n_in, servo_on_in,
                      batt_below_lost_in, batt_below_low_in}),
        .sync_out   (pins_s)
    );

    // State registers
    aep_mode_t             mode_ff;
    logic                  usage_pend_ff;
    logic                  boot_ff;
    aep_util_state_t       ut_state_ff;
    aep_alarm_t            alarm_ff;
    logic                  mt_valid_ff;
    logic                  refused_ff;
    logic                  refused_pulse_ff;
    logic                  done_pulse_ff;
    logic [ST_WIDTH-1:0]   sturn_ff;
    logic                  ack_ff;
    logic [31:0]           rd_ff;
    logic signed [MT_WIDTH-1:0] mturn_w;

    // Mode decode
    wire inc_mode_w = (mode_ff == AEP_MODE_INC);

    // Panel utility requests
    wire setup_req_w  = encoder_setup_utility_in & (ut_state_ff == AEP_UT_IDLE);
    wire setup_ok_w   = setup_req_w & ~servo_on_s;
    wire setup_bad_w  = setup_req_w & servo_on_s;
    wire clr_req_w    = encoder_alarm_clear_utility_in & ~encoder_setup_utility_in
                        & (ut_state_ff == AEP_UT_IDLE);

    // Utility sequencer next state
    aep_util_state_t nxt_ut_state;
    always_comb begin
        nxt_ut_state = ut_state_ff;
        case (ut_state_ff)
            AEP_UT_IDLE: begin
                if (setup_ok_w) begin
                    nxt_ut_state = AEP_UT_SETUP;
                end else if (clr_req_w) begin
                    nxt_ut_state = AEP_UT_CLEAR;
                end
            end
            AEP_UT_SETUP: begin
                nxt_ut_state = AEP_UT_IDLE;
            end
            AEP_UT_CLEAR: begin
                nxt_ut_state = AEP_UT_IDLE;
            end
            default: begin
                nxt_ut_state = AEP_UT_IDLE;
            end
        endcase
    end

    // Clearing of the absolute alarm group: panel only, both utilities
    wire do_setup_w   = (ut_state_ff == AEP_UT_SETUP);
    wire abs_clr_w    = do_setup_w | (ut_state_ff == AEP_UT_CLEAR);

    // Battery comparators matter only when the backup battery is used
    wire set_low_w    = batt_low_s & ~inc_mode_w;
    wire set_lost_w   = batt_lost_s & ~inc_mode_w;

    // Alarm latches; a new event wins over a clear in the same cycle
    aep_alarm_t nxt_alarm;
    assign nxt_alarm.batt_low  = set_low_w | (alarm_ff.batt_low & ~abs_clr_w);
    assign nxt_alarm.batt_lost = set_lost_w | (alarm_ff.batt_lost & ~abs_clr_w);
    assign nxt_alarm.abs_fault = enc_abs_fault_in
                                 | (alarm_ff.abs_fault & ~abs_clr_w);
    assign nxt_alarm.int_fault = enc_int_fault_in | alarm_ff.int_fault;

    // Multiturn data is invalid once the backup is lost, until setup
    wire nxt_mt_valid = ~set_lost_w & (do_setup_w | mt_valid_ff);

    // Refused-setup flag; alarm reset may clear this, never the encoder alarms
    wire nxt_refused  = setup_bad_w | (refused_ff & alarm_reset_input_n_s);

    // Multiturn counter, cleared by setup and by loss of backup data
    aep_mturn #(
        .WIDTH (MT_WIDTH)
    ) u_mturn (
        .clk_sys_in (clk_sys_in),
        .reset_n_in (reset_n_in),
        .ce_in      (ce_in),
        .fwd_in     (enc_fwd_turn_in),
        .rev_in     (enc_rev_turn_in),
        .clear_in   (do_setup_w | set_lost_w),
        .count_out  (mturn_w)
    );

    // Usage mode: taken from the stored setting only after a reset, so a
    // software write during operation waits for the next power cycle
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            mode_ff <= AEP_MODE_ABS;
            boot_ff <= 1'b1;
        end else if (ce_in) begin
            boot_ff <= 1'b0;
            if (boot_ff) begin
                mode_ff <= aep_mode_t'(encoder_usage_nv_in);
            end
        end
    end

    // Utility sequencer and latches
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            ut_state_ff <= AEP_UT_IDLE;
            alarm_ff    <= '0;
            mt_valid_ff <= 1'b1;
            refused_ff  <= 1'b0;
        end else if (ce_in) begin
            ut_state_ff <= nxt_ut_state;
            alarm_ff    <= nxt_alarm;
            mt_valid_ff <= nxt_mt_valid;
            refused_ff  <= nxt_refused;
        end
    end

    // One-cycle report pulses
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            done_pulse_ff    <= 1'b0;
            refused_pulse_ff <= 1'b0;
        end else if (ce_in) begin
            done_pulse_ff    <= abs_clr_w;
            refused_pulse_ff <= setup_bad_w;
        end
    end

    // Single-turn position sample
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            sturn_ff <= `AEP_RST_STURN;
        end else if (ce_in) begin
            sturn_ff <= enc_sturn_in;
        end
    end

    // Wishbone decode
    wire       req_w    = wb_req_in.cyc & wb_req_in.stb;
    wire [5:0] word_w   = wb_req_in.adr[7:2];
    wire hit_mt_w  = (word_w == 6'(`AEP_OFS_MTURN >> 2));
    wire hit_st_w  = (word_w == 6'(`AEP_OFS_STURN >> 2));
    wire hit_cfg_w = (word_w == 6'(`AEP_OFS_CONFIG >> 2));
    wire hit_sts_w = (word_w == 6'(`AEP_OFS_STATUS >> 2));

    // Write lands on the edge at which the master samples ack
    wire cfg_wr_w  = req_w & ack_ff & wb_req_in.we & hit_cfg_w & wb_req_in.sel[0];
    wire nxt_usage = cfg_wr_w ? wb_req_in.dat[`AEP_CFG_USAGE_BIT] : usage_pend_ff;

    // Status word
    logic [31:0] status_w;
    always_comb begin
        status_w                    = 32'h00000000;
        status_w[`AEP_ST_BATT_LOW]  = alarm_ff.batt_low;
        status_w[`AEP_ST_BATT_LOST] = alarm_ff.batt_lost;
        status_w[`AEP_ST_ABS_FAULT] = alarm_ff.abs_fault;
        status_w[`AEP_ST_INT_FAULT] = alarm_ff.int_fault;
        status_w[`AEP_ST_INC_MODE]  = inc_mode_w;
        status_w[`AEP_ST_MT_VALID]  = mt_valid_ff;
        status_w[`AEP_ST_SERVO_ON]  = servo_on_s;
        status_w[`AEP_ST_REFUSED]   = refused_ff;
    end

    // Read mux; unmapped words read zero and are still acknowledged
    wire [31:0] mt_word_w  = {{(32-MT_WIDTH){1'b0}}, mturn_w};
    wire [31:0] st_word_w  = {{(32-ST_WIDTH){1'b0}}, sturn_ff};
    wire [31:0] cfg_word_w = {31'h00000000, usage_pend_ff};
    wire [31:0] nxt_rd     = hit_mt_w  ? mt_word_w  :
                             hit_st_w  ? st_word_w  :
                             hit_cfg_w ? cfg_word_w :
                             hit_sts_w ? status_w   : 32'h00000000;

    // Ack one cycle after the request; dropped in the following cycle
    wire nxt_ack = req_w & ~ack_ff;

    // Bus slave registers
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            ack_ff        <= 1'b0;
            rd_ff         <= 32'h00000000;
            usage_pend_ff <= `AEP_RST_USAGE;
        end else if (ce_in) begin
            ack_ff        <= nxt_ack;
            rd_ff         <= nxt_ack ? nxt_rd : rd_ff;
            usage_pend_ff <= nxt_usage;
        end
    end

    // Outputs
    assign wb_dat_out             = rd_ff;
    assign wb_ack_out             = ack_ff;
    assign encoder_usage_pend_out = usage_pend_ff;
    assign incremental_mode_out   = inc_mode_w;
    assign multiturn_out          = mturn_w;
    assign multiturn_valid_out    = mt_valid_ff;
    assign alarm_out              = alarm_ff;
    assign abs_alarm_out          = alarm_ff.batt_low | alarm_ff.batt_lost
                                    | alarm_ff.abs_fault;
    assign util_done_out          = done_pulse_ff;
    assign setup_refused_out      = refused_pulse_ff;

endmodule

// ===== aep_defs.svh
// Register offsets, field positions and reset values of the encoder position block
`ifndef AEP_DEFS_SVH
`define AEP_DEFS_SVH

// Byte offsets of the 32-bit registers
`define AEP_OFS_MTURN      8'h00
`define AEP_OFS_STURN      8'h04
`define AEP_OFS_CONFIG     8'h08
`define AEP_OFS_STATUS     8'h0C

// Config register fields
`define AEP_CFG_USAGE_BIT  0

// Status register fields
`define AEP_ST_BATT_LOW    0
`define AEP_ST_BATT_LOST   1
`define AEP_ST_ABS_FAULT   2
`define AEP_ST_INT_FAULT   3
`define AEP_ST_INC_MODE    4
`define AEP_ST_MT_VALID    5
`define AEP_ST_SERVO_ON    6
`define AEP_ST_REFUSED     7

// Reset values
`define AEP_RST_USAGE      1'b0
`define AEP_RST_MTURN      16'h0000
`define AEP_RST_STURN      17'h00000

`endif

// ===== aep_pkg.sv
// Types shared by the encoder position block
package aep_pkg;

    // Encoder usage: absolute or incremental operation
    typedef enum logic [0:0] {
        AEP_MODE_ABS = 1'b0,
        AEP_MODE_INC = 1'b1
    } aep_mode_t;

    // Panel utility sequencer states
    typedef enum logic [1:0] {
        AEP_UT_IDLE  = 2'b00,
        AEP_UT_SETUP = 2'b01,
        AEP_UT_CLEAR = 2'b10
    } aep_util_state_t;

    // Latched encoder alarms
    typedef struct packed {
        logic int_fault;
        logic abs_fault;
        logic batt_lost;
        logic batt_low;
    } aep_alarm_t;

    // Classic Wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } aep_wb_req_t;

endpackage

// ===== aep_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module aep_sync #(
    parameter int WIDTH = 1
) (
    // Clock and control
    input  wire logic             clk_sys_in,
    input  wire logic             reset_n_in,
    input  wire logic             ce_in,
    // Asynchronous inputs and filtered result
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] out_ff;

    // Output follows only where stages two and three agree, per bit
    wire  [WIDTH-1:0] agree_w   = ~(s2_ff ^ s3_ff);
    wire  [WIDTH-1:0] nxt_out   = (s2_ff & agree_w) | (out_ff & ~agree_w);

    // First stage is read by the second stage only
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            meta_ff <= '0;
            s2_ff   <= '0;
            s3_ff   <= '0;
            out_ff  <= '0;
        end else if (ce_in) begin
            meta_ff <= async_in;
            s2_ff   <= meta_ff;
            s3_ff   <= s2_ff;
            out_ff  <= nxt_out;
        end
    end

    assign sync_out = out_ff;

endmodule

// ===== aep_mturn.sv
// Signed multiturn revolution counter with wrap at both ends
`timescale 1ns/1ps
module aep_mturn #(
    parameter int WIDTH = 16
) (
    // Clock and control
    input  wire logic                    clk_sys_in,
    input  wire logic                    reset_n_in,
    input  wire logic                    ce_in,
    // Turn events and clear
    input  wire logic                    fwd_in,
    input  wire logic                    rev_in,
    input  wire logic                    clear_in,
    // Count
    output logic signed [WIDTH-1:0]      count_out
);

    localparam logic signed [WIDTH-1:0] MAX_C = {1'b0, {(WIDTH-1){1'b1}}};
    localparam logic signed [WIDTH-1:0] MIN_C = {1'b1, {(WIDTH-1){1'b0}}};
    localparam logic signed [WIDTH-1:0] ONE_C = {{(WIDTH-1){1'b0}}, 1'b1};

    logic signed [WIDTH-1:0] count_ff;

    // Both events together cancel out
    wire step_up_w = fwd_in & ~rev_in;
    wire step_dn_w = rev_in & ~fwd_in;
    wire signed [WIDTH-1:0] up_w = (count_ff == MAX_C) ? MIN_C : count_ff + ONE_C;
    wire signed [WIDTH-1:0] dn_w = (count_ff == MIN_C) ? MAX_C : count_ff - ONE_C;
    wire signed [WIDTH-1:0] nxt_count = clear_in  ? '0   :
                                        step_up_w ? up_w :
                                        step_dn_w ? dn_w : count_ff;

    // Counter register
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            count_ff <= '0;
        end else if (ce_in) begin
            count_ff <= nxt_count;
        end
    end

    assign count_out = count_ff;

endmodule

// ===== aep_top_asserts.sv
// Port-level checker for the encoder position block, bound to its top
`timescale 1ns/1ps
module aep_top_chk
    import aep_pkg::*;
#(
    parameter int MT_WIDTH = 16,
    parameter int ST_WIDTH = 17
) (
    // Clock and control
    input wire logic                clk_sys_in,
    input wire logic                reset_n_in,
    input wire logic                ce_in,
    // Bus, turns and panel
    input wire aep_wb_req_t         wb_req_in,
    input wire logic                wb_ack_out,
    input wire logic                enc_fwd_turn_in,
    input wire logic                enc_rev_turn_in,
    input wire logic                batt_below_lost_in,
    input wire logic                encoder_setup_utility_in,
    input wire logic                encoder_alarm_clear_utility_in,
    // Status
    input wire logic [MT_WIDTH-1:0] multiturn_out,
    input wire logic                multiturn_valid_out,
    input wire aep_alarm_t          alarm_out,
    input wire logic                abs_alarm_out,
    input wire logic                util_done_out,
    input wire logic                setup_refused_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);

    // Any panel request; a clear lands two edges after it, so both edges are excluded
    logic util_req;
    assign util_req = encoder_setup_utility_in | encoder_alarm_clear_utility_in;

    AST_ACK_NEXT: assert property (
        ce_in && wb_req_in.cyc && wb_req_in.stb && !wb_ack_out |=> wb_ack_out)
        else $error("bus ack late");
    AST_ACK_ONE: assert property (ce_in && wb_ack_out |=> !wb_ack_out)
        else $error("bus ack longer than one cycle");
    AST_WRAP_UP: assert property (
        ce_in && enc_fwd_turn_in && !enc_rev_turn_in && multiturn_out == 16'h7FFF
        && !batt_below_lost_in && !alarm_out.batt_lost && !util_req && !$past(util_req)
        |=> multiturn_out == 16'h8000) else $error("forward wrap wrong");
    AST_WRAP_DN: assert property (
        ce_in && enc_rev_turn_in && !enc_fwd_turn_in && multiturn_out == 16'h8000
        && !batt_below_lost_in && !alarm_out.batt_lost && !util_req && !$past(util_req)
        |=> multiturn_out == 16'h7FFF) else $error("reverse wrap wrong");
    AST_CE_HOLD: assert property (
        !ce_in |=> $stable(multiturn_out) && $stable(alarm_out))
        else $error("state moved while clock enable low");
    AST_REFUSE_NODONE: assert property (setup_refused_out |=> !util_done_out)
        else $error("refused setup still completed");
    AST_DONE_CAUSE: assert property (util_done_out |-> $past(util_req, 2))
        else $error("utility done without request");
    AST_LOW_HELD: assert property (alarm_out.batt_low && !util_req && !$past(util_req)
        |=> alarm_out.batt_low) else $error("battery low alarm dropped");
    AST_INT_HELD: assert property (alarm_out.int_fault |=> alarm_out.int_fault)
        else $error("internal fault alarm dropped");
    AST_LOST_INVALID: assert property (alarm_out.batt_lost && $past(alarm_out.batt_lost)
        |-> !multiturn_valid_out) else $error("multiturn valid while lost");
    AST_ABS_GROUP: assert property (abs_alarm_out ==
        (alarm_out.batt_low | alarm_out.batt_lost | alarm_out.abs_fault))
        else $error("absolute alarm summary wrong");
endmodule

bind aep_top aep_top_chk #(.MT_WIDTH(MT_WIDTH), .ST_WIDTH(ST_WIDTH)) chk_u (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .ce_in(ce_in), .wb_req_in(wb_req_in),
    .wb_ack_out(wb_ack_out), .enc_fwd_turn_in(enc_fwd_turn_in),
    .enc_rev_turn_in(enc_rev_turn_in), .batt_below_lost_in(batt_below_lost_in),
    .encoder_setup_utility_in(encoder_setup_utility_in),
    .encoder_alarm_clear_utility_in(encoder_alarm_clear_utility_in),
    .multiturn_out(multiturn_out), .multiturn_valid_out(multiturn_valid_out),
    .alarm_out(alarm_out), .abs_alarm_out(abs_alarm_out), .util_done_out(util_done_out),
    .setup_refused_out(setup_refused_out));

// ===== aep_host.sv
// Host controller model: classic Wishbone master reading position words
`timescale 1ns/1ps
module aep_host
    import aep_pkg::*;
(
    // Clock
    input  wire logic        clk_sys_in,
    // Master side of the bus
    output aep_wb_req_t      wb_req_out,
    input  wire logic [31:0] wb_dat_in,
    input  wire logic        wb_ack_in
);
    initial wb_req_out = '0;

    // One access, held until ack is sampled; released lines show inverted junk
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                        output logic [31:0] rd, output bit ok);
        int n;
        n = 0;
        @(posedge clk_sys_in);
        wb_req_out <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: wd};
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (wb_ack_in !== 1'b1 && n < 50);
        ok = (wb_ack_in === 1'b1);
        rd = wb_dat_in;
        wb_req_out <= '{cyc: 1'b0, stb: 1'b0, we: ~we, adr: ~adr, sel: 4'h0, dat: ~wd};
    endtask
endmodule

// ===== aep_top_tb.sv
// Self-checking bench for the encoder position block
`timescale 1ns/1ps
`include "aep_defs.svh"
module aep_top_tb;
    import aep_pkg::*;
    typedef struct packed {
        logic        we;
        logic [7:0]  adr;
        logic [31:0] wd;
        logic [31:0] exp;
    } aep_row_t;
    // Bus rows, run once the count sits on the most negative value
    localparam aep_row_t ROWS [9] = '{
        '{1'b0, `AEP_OFS_MTURN, 32'h0, 32'h0000_8000},
        '{1'b0, `AEP_OFS_STURN, 32'h0, 32'h0001_ABCD},
        '{1'b0, `AEP_OFS_CONFIG, 32'h0, 32'h0}, '{1'b1, `AEP_OFS_CONFIG, 32'h1, 32'h0},
        '{1'b0, `AEP_OFS_CONFIG, 32'h0, 32'h1}, '{1'b0, 8'h10, 32'h0, 32'h0},
        '{1'b1, `AEP_OFS_MTURN, 32'h1234, 32'h0}, '{1'b0, `AEP_OFS_MTURN, 32'h0, 32'h0000_8000},
        '{1'b0, `AEP_OFS_STATUS, 32'h0, 32'h0000_0020}};
    logic clk_sys_in, reset_n_in, ce, fwd, rev, abs_f, int_f, nv, b_low, b_lost, servo, arst_n;
    logic setup_p, clr_p, ack, pend, inc, mt_ok, abs_al, done, refd, sd, sr;
    logic [31:0] rdat, rd;
    logic [15:0] mt;
    aep_wb_req_t req;
    aep_alarm_t  alm;
    int fails, n_compared;

    aep_host host_u (.clk_sys_in(clk_sys_in), .wb_req_out(req), .wb_dat_in(rdat), .wb_ack_in(ack));
    aep_top dut_u (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .ce_in(ce),
        .wb_req_in(req), .wb_dat_out(rdat), .wb_ack_out(ack), .enc_fwd_turn_in(fwd),
        .enc_rev_turn_in(rev), .enc_sturn_in(17'h1ABCD), .enc_abs_fault_in(abs_f),
        .enc_int_fault_in(int_f), .encoder_usage_nv_in(nv), .batt_below_low_in(b_low),
        .batt_below_lost_in(b_lost), .servo_on_in(servo), .alarm_reset_input_n_in(arst_n),
        .encoder_setup_utility_in(setup_p), .encoder_alarm_clear_utility_in(clr_p),
        .encoder_usage_pend_out(pend), .incremental_mode_out(inc), .multiturn_out(mt),
        .multiturn_valid_out(mt_ok), .alarm_out(alm), .abs_alarm_out(abs_al),
        .util_done_out(done), .setup_refused_out(refd));

    // 25 MHz system clock
    initial begin
        clk_sys_in = 1'b0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end

    task automatic close_out();
        if (fails == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        bit ok;
        host_u.xfer(we, adr, wd, rd, ok);
        if (!ok) begin
            fails++;
            close_out();
        end
    endtask
    // Reset long enough for the input synchronisers to flush
    task automatic do_reset();
        reset_n_in <= 1'b0;
        repeat (20) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        wt(3);
    endtask
    // Turn pulses spaced one idle cycle apart
    task automatic turns(input logic dir, input int n);
        repeat (n) begin
            @(posedge clk_sys_in);
            fwd <= dir;
            rev <= ~dir;
            @(posedge clk_sys_in);
            fwd <= 1'b0;
            rev <= 1'b0;
        end
        wt(2);
    endtask
    // Panel pulse, then watch a fixed window for done and refused
    task automatic util(input logic is_setup);
        @(posedge clk_sys_in);
        setup_p <= is_setup;
        clr_p <= ~is_setup;
        @(posedge clk_sys_in);
        setup_p <= 1'b0;
        clr_p <= 1'b0;
        sd = 1'b0;
        sr = 1'b0;
        // Refused answers right after the request edge, so the window opens there
        repeat (5) begin
            #1;
            sd |= done;
            sr |= refd;
            @(posedge clk_sys_in);
        end
        #1;
    endtask

    initial begin
        {fwd, rev, abs_f, int_f, nv, b_low, b_lost, servo, setup_p, clr_p} = '0;
        {fails, n_compared} = '0;
        arst_n = 1'b1;
        ce = 1'b1;
        reset_n_in = 1'b0;
        do_reset();
        check({28'h0, alm}, 32'h0);
        check({15'h0, mt_ok, mt}, 32'h1_0000);
        check({31'h0, inc}, 32'h0);
        turns(1'b1, 32767);
        check({16'h0, mt}, 32'h7FFF);
        turns(1'b1, 1);
        check({16'h0, mt}, 32'h8000);
        foreach (ROWS[i]) begin
            bus(ROWS[i].we, ROWS[i].adr, ROWS[i].wd);
            if (!ROWS[i].we) check(rd, ROWS[i].exp);
        end
        turns(1'b0, 1);
        bus(1'b0, `AEP_OFS_MTURN, 32'h0);
        check(rd, 32'h7FFF);
        // Setup with the servo on must be turned away
        servo <= 1'b1;
        wt(8);
        util(1'b1);
        check({30'h0, sd, sr}, 32'h1);
        bus(1'b0, `AEP_OFS_STATUS, 32'h0);
        check(rd, 32'hE0);
        check({16'h0, mt}, 32'h7FFF);
        servo <= 1'b0;
        wt(8);
        util(1'b1);
        check({30'h0, sd, sr}, 32'h2);
        check({16'h0, mt}, 32'h0);
        // Low battery survives the reset pin, goes with the clear utility
        @(posedge clk_sys_in);
        b_low <= 1'b1;
        wt(8);
        check({27'h0, abs_al, alm}, 32'h11);
        @(posedge clk_sys_in);
        b_low <= 1'b0;
        arst_n <= 1'b0;
        wt(8);
        @(posedge clk_sys_in);
        arst_n <= 1'b1;
        wt(8);
        check({28'h0, alm}, 32'h1);
        util(1'b0);
        check({27'h0, sd, alm}, 32'h10);
        // Lost battery voids the multiturn data until setup
        @(posedge clk_sys_in);
        b_lost <= 1'b1;
        wt(8);
        check({11'h0, mt_ok, alm, mt}, 32'h2_0000);
        @(posedge clk_sys_in);
        b_lost <= 1'b0;
        wt(8);
        check({28'h0, alm}, 32'h2);
        util(1'b1);
        check({27'h0, mt_ok, alm}, 32'h10);
        // Encoder faults: only the absolute one is cleared by setup
        @(posedge clk_sys_in);
        abs_f <= 1'b1;
        int_f <= 1'b1;
        @(posedge clk_sys_in);
        abs_f <= 1'b0;
        int_f <= 1'b0;
        wt(4);
        check({28'h0, alm}, 32'hC);
        util(1'b1);
        check({28'h0, alm}, 32'h8);
        // Usage setting waits for a power cycle
        check({30'h0, pend, inc}, 32'h2);
        // Turn pulses while the clock enable is low must not count
        @(posedge clk_sys_in);
        ce <= 1'b0;
        turns(1'b1, 2);
        check({16'h0, mt}, 32'h0);
        @(posedge clk_sys_in);
        ce <= 1'b1;
        nv <= 1'b1;
        do_reset();
        check({27'h0, inc, alm}, 32'h10);
        @(posedge clk_sys_in);
        b_low <= 1'b1;
        wt(8);
        check({28'h0, alm}, 32'h0);
        close_out();
    end
endmodule
